// [hw/oblc_option_loader.sv]
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "oblc_cfg.svh"
// Option byte loader: pulls the option bytes out of flash on every reset
// event and drives the configuration consumers from hidden registers.
module oblc_option_loader
   import oblc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Reset events
   input  wire logic        sys_reset_req,
   input  wire logic        ext_reset_req,
   input  wire logic        stop_recovery,
   input  wire logic        stop_mode,
   output logic             core_reset_hold,
   // Flash read port
   output logic             flash_rd_req,
   output logic [15:0]      flash_addr,
   input  wire logic        flash_rd_ack,
   input  wire logic [7:0]  flash_rd_data,
   // Option configuration outputs
   output logic             watchdog_timeout_action,
   output logic             watchdog_always_on,
   output logic [1:0]       oscillator_drive_select,
   output logic             brownout_always_on,
   output logic             code_read_protect,
   output logic             flash_write_protect,
   // Watchdog consumer
   input  wire logic        watchdog_enable_instruction,
   input  wire logic        wdt_timeout,
   output logic             wdt_running,
   output logic             wdt_irq_req,
   output logic             wdt_reset_req,
   // Brown-out and debug consumers
   output logic             brownout_enable,
   output logic             user_code_readable,
   output logic             debug_port_full,
   // Flash write protection consumer
   input  wire logic        user_prog_req,
   input  wire logic        user_page_erase_req,
   input  wire logic        user_mass_erase_req,
   input  wire logic        debug_mass_erase_req,
   output logic             prog_grant,
   output logic             page_erase_grant,
   output logic             mass_erase_grant
);

   // ============================================================
   // Declarations
   oblc_rd_if rd ();

   oblc_ld_e    st_r;
   oblc_ld_e    st_nxt;
   logic        hold_r;
   logic        start_r;
   logic [15:0] addr_r;
   logic [7:0]  user_byte_r;
   logic [7:0]  rsvd_byte_r;
   logic        loaded_r;
   logic        bit_bad_r;
   logic        byte_bad_r;
   logic [7:0]  load_cnt_r;
   logic [3:0]  ctrl_settle_r;
   logic [31:0] prdata_r;

   // Hidden option configuration registers; no bus path reaches them
   logic        opt_wdt_act_r;
   logic        opt_watchdog_always_on_r;
   logic [1:0]  opt_osc_r;
   logic        opt_bo_ao_r;
   logic        opt_rdprot_r;
   logic        opt_wrprot_r;

   // Consumer outputs, all from flip-flops
   logic        wdt_run_r;
   logic        wdt_irq_r;
   logic        wdt_rst_r;
   logic        bo_en_r;
   logic        prog_g_r;
   logic        page_g_r;
   logic        mass_g_r;

   // ============================================================
   // Reset event decode
   // Any of the three sources restarts the load, even one already in flight,
   // so a late reset can never leave a half-loaded option set in force.
   wire reload_evt = sys_reset_req | ext_reset_req | stop_recovery;
   wire user_done  = (st_r == OBLC_LD_USER) && rd.done;
   wire rsvd_done  = (st_r == OBLC_LD_RSVD) && rd.done;
   wire commit     = (st_r == OBLC_LD_COMMIT);

   // ============================================================
   // Flash reader
   oblc_flash_reader u_reader (
      .pclk          (pclk),
      .presetn       (presetn),
      .rd            (rd.reader),
      .flash_rd_req  (flash_rd_req),
      .flash_addr    (flash_addr),
      .flash_rd_ack  (flash_rd_ack),
      .flash_rd_data (flash_rd_data)
   );

   assign rd.start  = start_r;
   assign rd.addr   = addr_r;
   assign rd.settle = ctrl_settle_r;

   // ============================================================
   // Load sequence: user byte, then the reserved byte, then commit
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         OBLC_LD_IDLE: begin
            st_nxt = OBLC_LD_IDLE;
         end
         OBLC_LD_USER: begin
            if (rd.done) st_nxt = OBLC_LD_RSVD;
         end
         OBLC_LD_RSVD: begin
            if (rd.done) st_nxt = OBLC_LD_COMMIT;
         end
         OBLC_LD_COMMIT: begin
            st_nxt = OBLC_LD_IDLE;
         end
         default: begin
            st_nxt = OBLC_LD_IDLE;
         end
      endcase
      // A reset event restarts from the user byte at any point
      if (reload_evt) st_nxt = OBLC_LD_USER;
   end

   // State register; power-on release starts a load on its own
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= OBLC_LD_USER;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Read launch: one start pulse per byte
   // The reader is busy after a restart for at most one read; the loader waits for its done
   // and takes it as the user byte; only a done in the reload cycle itself is dropped by the restart below.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_r <= 1'b1;
         addr_r  <= `OBLC_ADDR_USER;
      end else if (reload_evt) begin
         start_r <= 1'b1;
         addr_r  <= `OBLC_ADDR_USER;
      end else if (user_done) begin
         start_r <= 1'b1;
         addr_r  <= `OBLC_ADDR_RSVD;
      end else begin
         start_r <= 1'b0;
      end
   end

   // Byte capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         user_byte_r <= `OBLC_ERASED;
         rsvd_byte_r <= `OBLC_ERASED;
      end else begin
         if (user_done && !reload_evt) user_byte_r <= rd.data;
         if (rsvd_done && !reload_evt) rsvd_byte_r <= rd.data;
      end
   end

   // ============================================================
   // Processor reset hold
   // Held from the event until the commit cycle has updated every option,
   // so code fetch never sees a mix of old and new settings.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_r <= 1'b1;
      end else if (reload_evt) begin
         hold_r <= 1'b1;
      end else if (commit) begin
         hold_r <= 1'b0;
      end
   end

   // ============================================================
   // Hidden option registers
   // Written only in the commit cycle of a reset load; a flash rewrite in
   // normal running leaves them alone until the next reset event.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_wdt_act_r <= 1'b1;
         opt_watchdog_always_on_r  <= 1'b1;
         opt_osc_r     <= OBLC_OSC_HIGH;
         opt_bo_ao_r   <= 1'b1;
         opt_rdprot_r  <= 1'b1;
         opt_wrprot_r  <= 1'b1;
      end else if (commit && !reload_evt) begin
         opt_wdt_act_r <= user_byte_r[`OBLC_BIT_WDT_ACT];
         opt_watchdog_always_on_r  <= user_byte_r[`OBLC_BIT_WATCHDOG_ALWAYS_ON];
         opt_osc_r     <= user_byte_r[`OBLC_BIT_OSC_HI:`OBLC_BIT_OSC_LO];
         opt_bo_ao_r   <= user_byte_r[`OBLC_BIT_BO_AO];
         opt_rdprot_r  <= user_byte_r[`OBLC_BIT_RDPROT];
         opt_wrprot_r  <= user_byte_r[`OBLC_BIT_WRPROT];
      end
   end

   // Load bookkeeping, reported on the status register
   // Reserved bits are checked, not enforced: a bad value is only flagged.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_r   <= 1'b0;
         bit_bad_r  <= 1'b0;
         byte_bad_r <= 1'b0;
         load_cnt_r <= 8'h00;
      end else if (reload_evt) begin
         loaded_r   <= 1'b0;
      end else if (commit) begin
         loaded_r   <= 1'b1;
         bit_bad_r  <= ~user_byte_r[`OBLC_BIT_RSVD];
         byte_bad_r <= (rsvd_byte_r != `OBLC_ERASED);
         load_cnt_r <= load_cnt_r + 8'h01;
      end
   end

   // ============================================================
   // Watchdog consumer
   // Always-on forces it running; otherwise the enable instruction starts
   // it and only a reset event stops it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_run_r <= 1'b0;
      end else if (reload_evt || hold_r) begin
         wdt_run_r <= 1'b0;
      end else if (!opt_watchdog_always_on_r) begin
         wdt_run_r <= 1'b1;
      end else if (watchdog_enable_instruction) begin
         wdt_run_r <= 1'b1;
      end
   end

   // Timeout routing by the action bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_irq_r <= 1'b0;
         wdt_rst_r <= 1'b0;
      end else begin
         wdt_irq_r <= wdt_timeout && wdt_run_r && !opt_wdt_act_r;
         wdt_rst_r <= wdt_timeout && wdt_run_r && opt_wdt_act_r;
      end
   end

   // ============================================================
   // Brown-out and flash protection consumers
   // Debugger mass erase stays open even when user writes are blocked,
   // which is the only way back from a locked part.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bo_en_r  <= 1'b1;
         prog_g_r <= 1'b0;
         page_g_r <= 1'b0;
         mass_g_r <= 1'b0;
      end else begin
         bo_en_r  <= opt_bo_ao_r || !stop_mode;
         prog_g_r <= user_prog_req && opt_wrprot_r && !hold_r;
         page_g_r <= user_page_erase_req && opt_wrprot_r && !hold_r;
         mass_g_r <= !hold_r && (debug_mass_erase_req ||
                     (user_mass_erase_req && opt_wrprot_r));
      end
   end

   // ============================================================
   // APB slave: zero wait states
   // Only control and status decode; the option registers have no address.
   wire apb_setup  = psel && !penable;
   wire apb_access = psel && penable;
   wire hit_ctrl   = (paddr == `OBLC_OFS_CTRL);
   wire hit_stat   = (paddr == `OBLC_OFS_STAT);
   wire hit_any    = hit_ctrl || hit_stat;
   wire wr_ctrl    = apb_access && pwrite && hit_ctrl;

   // Read mux, sampled in the setup phase
   wire [31:0] ctrl_rd = {28'h0000000, ctrl_settle_r};
   wire [31:0] stat_rd = {16'h0000, load_cnt_r, 4'h0,
                          byte_bad_r, bit_bad_r, loaded_r, hold_r};
   wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                         hit_stat ? stat_rd : 32'h00000000;

   // Control register: flash settle cycles used by the next load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_settle_r <= `OBLC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_settle_r <= pwdata[3:0];
      end
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (apb_setup) begin
         prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = apb_access && !hit_any; // Unmapped, incl. option space
   assign prdata  = prdata_r;

   // ============================================================
   // Output drive
   assign core_reset_hold         = hold_r;
   assign watchdog_timeout_action = opt_wdt_act_r;
   assign watchdog_always_on      = opt_watchdog_always_on_r;
   assign oscillator_drive_select = opt_osc_r;
   assign brownout_always_on      = opt_bo_ao_r;
   assign code_read_protect       = opt_rdprot_r;
   assign flash_write_protect     = opt_wrprot_r;
   assign wdt_running             = wdt_run_r;
   assign wdt_irq_req             = wdt_irq_r;
   assign wdt_reset_req           = wdt_rst_r;
   assign brownout_enable         = bo_en_r;
   assign user_code_readable      = opt_rdprot_r;
   assign debug_port_full         = opt_rdprot_r;
   assign prog_grant              = prog_g_r;
   assign page_erase_grant        = page_g_r;
   assign mass_erase_grant        = mass_g_r;

endmodule

// [shared/oblc_cfg.svh]
`ifndef OBLC_CFG_SVH
`define OBLC_CFG_SVH
// Overview of operation
// - Every system reset, external reset or stop recovery reloads options from flash.
// - Options are loaded and in force before the processor leaves reset.
// - Option configuration registers are invisible to software, never read or written.
// - Flash option changes act only after the next reset reload.
// - Bit 7 picks watchdog timeout action: 0 interrupt, 1 reset.
// - Bit 6 zero forces watchdog on; one waits for enable instruction.
// - Bits 5:4 pick oscillator mode: RC, low, medium, high power.
// - Bit 3 zero drops brown-out protection in stop mode.
// - Bit 2 zero hides user code and limits debugger commands.
// - Bit 0 zero blocks user program and erase; debugger mass erase stays.
// - Flash option bytes survive resets; loader only reads them.

// ============================================================
// Flash locations of the option bytes
`define OBLC_ADDR_USER    16'h0000
`define OBLC_ADDR_RSVD    16'h0001
`define OBLC_ERASED       8'hFF

// ============================================================
// Field positions inside the user option byte
`define OBLC_BIT_WDT_ACT  7
`define OBLC_BIT_WATCHDOG_ALWAYS_ON   6
`define OBLC_BIT_OSC_HI   5
`define OBLC_BIT_OSC_LO   4
`define OBLC_BIT_BO_AO    3
`define OBLC_BIT_RDPROT   2
`define OBLC_BIT_RSVD     1
`define OBLC_BIT_WRPROT   0

// ============================================================
// APB register map and fields
`define OBLC_OFS_CTRL     12'h000
`define OBLC_OFS_STAT     12'h004
`define OBLC_CTRL_RST     4'h0
`define OBLC_STAT_BUSY    0
`define OBLC_STAT_LOADED  1
`define OBLC_STAT_BIT_BAD 2
`define OBLC_STAT_BYTE_BAD 3
`define OBLC_STAT_CNT_LO  8
`endif

// [shared/oblc_pkg.sv]
`include "oblc_cfg.svh"
package oblc_pkg;
   // Loader sequence
   typedef enum logic [1:0] {
      OBLC_LD_IDLE,
      OBLC_LD_USER,
      OBLC_LD_RSVD,
      OBLC_LD_COMMIT
   } oblc_ld_e;
   // Flash read sequence
   typedef enum logic [1:0] {
      OBLC_RD_IDLE,
      OBLC_RD_SETTLE,
      OBLC_RD_WAIT
   } oblc_rd_e;
   // Oscillator drive modes, in option field order
   typedef enum logic [1:0] {
      OBLC_OSC_RC,
      OBLC_OSC_LOW,
      OBLC_OSC_MED,
      OBLC_OSC_HIGH
   } oblc_osc_e;
endpackage

// [shared/oblc_rd_if.sv]
`timescale 1ns/1ps
// Carries one byte read between the loader and the flash reader
interface oblc_rd_if;
   logic        start;
   logic [15:0] addr;
   logic [3:0]  settle;
   logic        done;
   logic [7:0]  data;
   modport loader (output start, output addr, output settle, input done, input data);
   modport reader (input start, input addr, input settle, output done, output data);
endinterface

// [hw/oblc_flash_reader.sv]
`timescale 1ns/1ps
`include "oblc_cfg.svh"
// Read-only flash port: waits the settle count, then holds the request until ack
module oblc_flash_reader
   import oblc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   oblc_rd_if.reader        rd,
   output logic             flash_rd_req,
   output logic [15:0]      flash_addr,
   input  wire logic        flash_rd_ack,
   input  wire logic [7:0]  flash_rd_data
);
   oblc_rd_e    st_r;
   oblc_rd_e    st_nxt;
   logic [3:0]  cnt_r;
   logic [15:0] addr_r;
   logic [7:0]  data_r;
   logic        done_r;
   wire         settle_end = (cnt_r == rd.settle);

   // ============================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         OBLC_RD_IDLE:   if (rd.start) st_nxt = OBLC_RD_SETTLE;
         OBLC_RD_SETTLE: if (settle_end) st_nxt = OBLC_RD_WAIT;
         OBLC_RD_WAIT:   if (flash_rd_ack) st_nxt = OBLC_RD_IDLE;
         default:        st_nxt = OBLC_RD_IDLE;
      endcase
   end

   // Sequence and capture; there is no write path at all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r   <= OBLC_RD_IDLE;
         cnt_r  <= 4'h0;
         addr_r <= 16'h0000;
         data_r <= 8'h00;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= (st_r == OBLC_RD_SETTLE) ? cnt_r + 4'h1 : 4'h0;
         if (rd.start) addr_r <= rd.addr;
         done_r <= (st_r == OBLC_RD_WAIT) && flash_rd_ack;
         if ((st_r == OBLC_RD_WAIT) && flash_rd_ack) data_r <= flash_rd_data;
      end
   end

   assign flash_rd_req = (st_r == OBLC_RD_WAIT);
   assign flash_addr   = addr_r;
   assign rd.done      = done_r;
   assign rd.data      = data_r;
endmodule

// [sim/oblc_flash_model.sv]
`timescale 1ns/1ps
// ======
// Flash array: two option bytes, ack after a set delay
module oblc_flash_model (
   input  wire logic        pclk,
   input  wire logic        flash_rd_req,
   input  wire logic [15:0] flash_addr,
   output logic             flash_rd_ack,
   output logic [7:0]       flash_rd_data
);
   logic [7:0] mem [2] = '{8'hFF, 8'hFF}; // Erased bytes keep reserved bits at one
   int         ack_delay = 0; // Extra wait cycles, set by the bench
   int         cnt = 0;
   initial flash_rd_ack = 1'b0;
   initial flash_rd_data = 8'h00;
   // ======
   // No write path here, so contents survive every reset
   // Data toggles off an ack so a stale byte never passes
   always @(posedge pclk) begin
      flash_rd_ack <= 1'b0;
      flash_rd_data <= ~flash_rd_data;
      if (flash_rd_req && !flash_rd_ack && cnt >= ack_delay) begin
         flash_rd_ack <= 1'b1;
         flash_rd_data <= mem[flash_addr[0]]; // User byte 0000H, reserved 0001H
         cnt <= 0;
      end else if (flash_rd_req && !flash_rd_ack) begin
         cnt <= cnt + 1;
      end else begin
         cnt <= 0;
      end
   end
endmodule

// [sim/oblc_option_loader_asserts.sv]
`timescale 1ns/1ps
// ======
// Port checks for the option loader
module oblc_option_loader_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sys_reset_req,
   input wire logic        ext_reset_req,
   input wire logic        stop_recovery,
   input wire logic        stop_mode,
   input wire logic        core_reset_hold,
   input wire logic        flash_rd_req,
   input wire logic [15:0] flash_addr,
   input wire logic        flash_rd_ack,
   input wire logic        watchdog_timeout_action,
   input wire logic        watchdog_always_on,
   input wire logic [1:0]  oscillator_drive_select,
   input wire logic        brownout_always_on,
   input wire logic        code_read_protect,
   input wire logic        flash_write_protect,
   input wire logic        wdt_timeout,
   input wire logic        wdt_running,
   input wire logic        wdt_irq_req,
   input wire logic        brownout_enable,
   input wire logic        user_code_readable,
   input wire logic        user_prog_req,
   input wire logic        debug_mass_erase_req,
   input wire logic        prog_grant,
   input wire logic        mass_erase_grant
);
   // ======
   // One clock domain: defaults carry clock and reset
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire       ev  = sys_reset_req | ext_reset_req | stop_recovery;
   wire       run = !core_reset_hold;
   wire [6:0] opt = {watchdog_timeout_action, watchdog_always_on, oscillator_drive_select,
      brownout_always_on, code_read_protect, flash_write_protect};
   // ======
   // Load sequence and register space
   property p_ev_hold; ev |=> core_reset_hold; endproperty
   a_ev_hold: assert property (p_ev_hold) else $error("no hold after reset event");
   property p_rd_hold; flash_rd_req |-> core_reset_hold; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("flash read outside hold");
   property p_latch; $changed(opt) |-> $fell(core_reset_hold); endproperty
   a_latch: assert property (p_latch) else $error("options moved off commit");
   property p_req; flash_rd_req && !flash_rd_ack && !ev && !$past(ev)
      |=> flash_rd_req && $stable(flash_addr); endproperty
   a_req: assert property (p_req) else $error("flash request dropped early");
   property p_unmap; psel && penable && paddr != 12'h000 && paddr != 12'h004
      |-> pslverr && pready; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
   // ======
   // Consumers of the loaded options
   property p_wd_irq; wdt_timeout && wdt_running && !watchdog_timeout_action && run
      |=> wdt_irq_req; endproperty
   a_wd_irq: assert property (p_wd_irq) else $error("watchdog irq missing");
   property p_wd_ao; run && !watchdog_always_on ##1 run |-> wdt_running; endproperty
   a_wd_ao: assert property (p_wd_ao) else $error("watchdog not forced on");
   property p_wd_stop; core_reset_hold |=> !wdt_running; endproperty
   a_wd_stop: assert property (p_wd_stop) else $error("watchdog runs in reset");
   property p_bo; stop_mode && !brownout_always_on |=> !brownout_enable; endproperty
   a_bo: assert property (p_bo) else $error("brownout kept in stop");
   property p_rp; user_code_readable == code_read_protect; endproperty
   a_rp: assert property (p_rp) else $error("code readable mismatch");
   property p_wp; user_prog_req && run |=> prog_grant == $past(flash_write_protect);
   endproperty
   a_wp: assert property (p_wp) else $error("program grant wrong");
   property p_dbg; debug_mass_erase_req && run |=> mass_erase_grant; endproperty
   a_dbg: assert property (p_dbg) else $error("debug mass erase refused");
endmodule
bind oblc_option_loader oblc_option_loader_asserts oblc_option_loader_asserts_i (.*);

// [sim/testbench.sv]
`timescale 1ns/1ps
// ======
// Bench: APB tasks and a table of option bytes
module testbench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, core_reset_hold, flash_rd_req, flash_rd_ack;
   logic        sys_reset_req = 1'b0, ext_reset_req = 1'b0, stop_recovery = 1'b0;
   logic        stop_mode = 1'b0, watchdog_enable_instruction = 1'b0, wdt_timeout = 1'b0;
   logic        user_prog_req = 1'b0, user_page_erase_req = 1'b0;
   logic        user_mass_erase_req = 1'b0, debug_mass_erase_req = 1'b0;
   logic [15:0] flash_addr;
   logic [7:0]  flash_rd_data;
   logic [1:0]  oscillator_drive_select;
   logic        watchdog_timeout_action, watchdog_always_on, brownout_always_on;
   logic        code_read_protect, flash_write_protect, wdt_running, wdt_irq_req;
   logic        wdt_reset_req, brownout_enable, user_code_readable, debug_port_full;
   logic        prog_grant, page_erase_grant, mass_erase_grant;
   logic [7:0]  opt_a [5] = '{8'h0E, 8'h96, 8'h63, 8'hFF, 8'hFD};
   logic [7:0]  opt_b [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F};
   logic [7:0]  prev = 8'hFF;
   int          n_fail = 0;
   int          total_checks = 0;
   wire  [6:0]  opts = {watchdog_timeout_action, watchdog_always_on, oscillator_drive_select,
      brownout_always_on, code_read_protect, flash_write_protect};

   oblc_option_loader oblc_option_loader_i (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .sys_reset_req, .ext_reset_req, .stop_recovery, .stop_mode,
      .core_reset_hold, .flash_rd_req, .flash_addr, .flash_rd_ack, .flash_rd_data,
      .watchdog_timeout_action, .watchdog_always_on, .oscillator_drive_select,
      .brownout_always_on, .code_read_protect, .flash_write_protect,
      .watchdog_enable_instruction, .wdt_timeout, .wdt_running, .wdt_irq_req,
      .wdt_reset_req, .brownout_enable, .user_code_readable, .debug_port_full,
      .user_prog_req, .user_page_erase_req, .user_mass_erase_req, .debug_mass_erase_req,
      .prog_grant, .page_erase_grant, .mass_erase_grant
   );
   oblc_flash_model oblc_flash_model_i (
      .pclk, .flash_rd_req, .flash_addr, .flash_rd_ack, .flash_rd_data
   );

   // ======
   // Clock, comparison and closing report
   always #50 pclk = ~pclk;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ======
   // APB transfer; one idle edge after release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
      int n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         test_done();
      end
      chk("pslverr", {31'h0, err}, {31'h0, pslverr});
      if (!wr) chk("prdata", exp, prdata);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Bounded wait for the load to end
   task automatic wait_load();
      int n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (core_reset_hold !== 1'b0 && n < 300);
      if (core_reset_hold !== 1'b0) begin
         n_fail++;
         test_done();
      end
   endtask
   // Drive each consumer; answers come from byte b
   task automatic probe(input logic [7:0] b);
      chk("options", {25'h0, b[7:2], b[0]}, {25'h0, opts});
      @(posedge pclk);
      #1;
      chk("wdt_running", {31'h0, ~b[6]}, {31'h0, wdt_running});
      @(posedge pclk);
      watchdog_enable_instruction <= 1'b1;
      user_prog_req <= 1'b1;
      user_page_erase_req <= 1'b1;
      user_mass_erase_req <= 1'b1;
      stop_mode <= 1'b1;
      @(posedge pclk);
      watchdog_enable_instruction <= 1'b0;
      user_prog_req <= 1'b0;
      user_page_erase_req <= 1'b0;
      user_mass_erase_req <= 1'b0;
      stop_mode <= 1'b0;
      debug_mass_erase_req <= 1'b1;
      #1;
      chk("wdt_enabled", 32'h1, {31'h0, wdt_running});
      chk("grants", {30'h0, b[0], b[0]}, {30'h0, prog_grant, page_erase_grant});
      chk("user_mass", {31'h0, b[0]}, {31'h0, mass_erase_grant});
      chk("brownout", {31'h0, b[3]}, {31'h0, brownout_enable});
      chk("rdprot", {30'h0, b[2], b[2]}, {30'h0, user_code_readable, debug_port_full});
      @(posedge pclk);
      debug_mass_erase_req <= 1'b0;
      wdt_timeout <= 1'b1;
      #1;
      chk("dbg_mass", 32'h1, {31'h0, mass_erase_grant});
      @(posedge pclk);
      wdt_timeout <= 1'b0;
      #1;
      chk("wdt_action", {30'h0, ~b[7], b[7]}, {30'h0, wdt_irq_req, wdt_reset_req});
   endtask

   // ======
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      chk("reset_state", 32'hFF, {24'h0, core_reset_hold, opts});
      presetn <= 1'b1;
      wait_load();
      probe(8'hFF);
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 12'h004, 32'h0, 32'h0000_0102, 1'b0);
      apb(1'b1, 12'h000, 32'h2, 32'h0, 1'b0);
      apb(1'b0, 12'h000, 32'h0, 32'h2, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h00C, 32'hFF, 32'h0, 1'b1);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         oblc_flash_model_i.mem[0] = opt_a[i];
         oblc_flash_model_i.mem[1] = opt_b[i];
         oblc_flash_model_i.ack_delay = i;
         repeat (3) @(posedge pclk);
         #1;
         chk("no_early_take", {25'h0, prev[7:2], prev[0]}, {25'h0, opts});
         @(posedge pclk);
         sys_reset_req <= (i % 3 == 0);
         ext_reset_req <= (i % 3 == 1);
         stop_recovery <= (i % 3 == 2);
         @(posedge pclk);
         sys_reset_req <= 1'b0;
         ext_reset_req <= 1'b0;
         stop_recovery <= 1'b0;
         if (i == 2) begin
            repeat (3) @(posedge pclk);
            ext_reset_req <= 1'b1;
            @(posedge pclk);
            ext_reset_req <= 1'b0;
         end
         wait_load();
         probe(opt_a[i]);
         @(posedge pclk);
         apb(1'b0, 12'h004, 32'h0, {16'h0, 8'(i + 2), 4'h0, opt_b[i] != 8'hFF,
             ~opt_a[i][1], 2'b10}, 1'b0);
         prev = opt_a[i];
         $display("test option set %0d done", i);
      end
      test_done();
   end
endmodule
